// ---- inc/radio_status_pkg.sv ----
package radio_status_pkg;

  // ==========================================================================
  // address map
  localparam int          ADDR_W              = 6;
  localparam int          DATA_W              = 8;
  localparam logic [5:0]  OFS_WAKE_TIMER_HIGH = 6'h36;
  localparam logic [5:0]  OFS_WAKE_TIMER_LOW  = 6'h37;
  localparam logic [5:0]  OFS_PACKET_STATUS   = 6'h38;
  localparam logic [5:0]  OFS_SYNTH_CAL       = 6'h39;
  localparam logic [5:0]  OFS_TX_FILL_LEVEL   = 6'h3a;
  localparam logic [5:0]  OFS_RX_FILL_LEVEL   = 6'h3b;
  localparam logic [5:0]  OFS_OSC_CAL_A       = 6'h3c;
  localparam logic [5:0]  OFS_OSC_CAL_B       = 6'h3d;

  // ==========================================================================
  // field positions
  localparam int          POS_CRC_OK          = 7;
  localparam int          POS_CARRIER_SENSE   = 6;
  localparam int          POS_PREAMBLE_MET    = 5;
  localparam int          POS_CHANNEL_CLEAR   = 4;
  localparam int          POS_SYNC_FOUND      = 3;
  localparam int          POS_PIN2            = 2;
  localparam int          POS_PIN0            = 0;
  localparam int          POS_QUEUE_FLAG      = 7;
  localparam int          COUNT_W             = 7;
  localparam int          OSC_CAL_W           = 7;
  localparam int          TIMER_W             = 16;
  localparam int          SYNC_STAGES         = 2;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  RST_BYTE            = 8'h00;
  localparam logic [6:0]  RST_OSC_CAL         = 7'h00;
  localparam logic [15:0] RST_TIMER           = 16'h0000;
  localparam logic        RST_FLAG            = 1'b0;

  // ==========================================================================
  // sync-found tracker states
  typedef enum logic [0:0] {
    SF_IDLE  = 1'b0,
    SF_FOUND = 1'b1
  } sync_state_t;

endpackage

// ---- hdl/level_sync.sv ----
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ==========================================================================
  // two-stage synchroniser, one per bit; first stage feeds only the second
  logic [WIDTH-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          meta[g]   <= radio_status_pkg::RST_FLAG;
          o_sync[g] <= radio_status_pkg::RST_FLAG;
        end else begin
          meta[g]   <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule

// ---- hdl/sync_found_tracker.sv ----
`timescale 1ns/1ps
module sync_found_tracker (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_tx_active,
  input  wire logic i_sync_detected,
  input  wire logic i_packet_end,
  input  wire logic i_addr_reject,
  input  wire logic i_rx_overflow_enter,
  input  wire logic i_tx_underflow_enter,
  output logic      o_sync_found
);

  // ==========================================================================
  // flag state machine
  radio_status_pkg::sync_state_t state;
  radio_status_pkg::sync_state_t next_state;
  logic                          drop;

  always_comb begin
    drop = i_packet_end;
    drop = drop | (~i_tx_active & (i_addr_reject | i_rx_overflow_enter));
    drop = drop | (i_tx_active & i_tx_underflow_enter);
  end

  // a new sync word in the same cycle as a drop wins, so no packet start is lost
  always_comb begin
    case (state)
      radio_status_pkg::SF_IDLE: begin
        next_state = i_sync_detected ? radio_status_pkg::SF_FOUND
                                     : radio_status_pkg::SF_IDLE;
      end
      radio_status_pkg::SF_FOUND: begin
        if (i_sync_detected) begin
          next_state = radio_status_pkg::SF_FOUND;
        end else if (drop) begin
          next_state = radio_status_pkg::SF_IDLE;
        end else begin
          next_state = radio_status_pkg::SF_FOUND;
        end
      end
      default: begin
        next_state = radio_status_pkg::SF_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state <= radio_status_pkg::SF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign o_sync_found = (state == radio_status_pkg::SF_FOUND);

endmodule

// ---- hdl/radio_status_register_bank.sv ----
`timescale 1ns/1ps
module radio_status_register_bank (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // register access from the serial port decoder
  input  wire logic        i_rd_en,
  input  wire logic [5:0]  i_rd_addr,
  input  wire logic        i_wr_en,
  input  wire logic [5:0]  i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  // wake timer
  input  wire logic [15:0] i_wake_timer,
  // packet engine events, one-cycle pulses, plus the transmit-active level
  input  wire logic        i_crc_done,
  input  wire logic        i_crc_match,
  input  wire logic        i_rx_start,
  input  wire logic        i_sync_detected,
  input  wire logic        i_packet_end,
  input  wire logic        i_addr_reject,
  input  wire logic        i_rx_overflow_enter,
  input  wire logic        i_tx_underflow_enter,
  input  wire logic        i_tx_active,
  // asynchronous live levels
  input  wire logic        i_carrier_sense,
  input  wire logic        i_preamble_quality_met,
  input  wire logic        i_channel_clear,
  input  wire logic        i_general_out_pin_2,
  input  wire logic        i_general_out_pin_0,
  // calibration and queue state
  input  wire logic [7:0]  i_synth_cal,
  input  wire logic [6:0]  i_tx_byte_count,
  input  wire logic        i_tx_queue_underrun,
  input  wire logic [6:0]  i_rx_byte_count,
  input  wire logic        i_rx_queue_overrun,
  input  wire logic        i_osc_cal_done,
  input  wire logic [6:0]  i_osc_cal_a,
  input  wire logic [6:0]  i_osc_cal_b,
  // answers
  output logic [7:0]       o_rd_data,
  output logic             o_rd_valid,
  output logic             o_wr_ignored,
  output logic             o_crc_ok,
  output logic             o_sync_found
);

  // ==========================================================================
  // decode helper, used by the read and the write path
  function automatic logic is_mapped(input logic [5:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      radio_status_pkg::OFS_WAKE_TIMER_HIGH,
      radio_status_pkg::OFS_WAKE_TIMER_LOW,
      radio_status_pkg::OFS_PACKET_STATUS,
      radio_status_pkg::OFS_SYNTH_CAL,
      radio_status_pkg::OFS_TX_FILL_LEVEL,
      radio_status_pkg::OFS_RX_FILL_LEVEL,
      radio_status_pkg::OFS_OSC_CAL_A,
      radio_status_pkg::OFS_OSC_CAL_B: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ==========================================================================
  // synchronised live levels
  logic [4:0] live_async;
  logic [4:0] live_sync;
  logic       carrier_sense_s;
  logic       preamble_met_s;
  logic       channel_clear_s;
  logic       pin2_s;
  logic       pin0_s;

  assign live_async = {i_carrier_sense, i_preamble_quality_met, i_channel_clear,
                       i_general_out_pin_2, i_general_out_pin_0};

  level_sync #(
    .WIDTH (5)
  ) u_live_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (live_async),
    .o_sync    (live_sync)
  );

  assign carrier_sense_s = live_sync[4];
  assign preamble_met_s  = live_sync[3];
  assign channel_clear_s = live_sync[2];
  assign pin2_s          = live_sync[1];
  assign pin0_s          = live_sync[0];

  // ==========================================================================
  // sync word flag
  logic sync_found;

  sync_found_tracker u_sync_found (
    .i_sys_clk            (i_sys_clk),
    .i_sys_rst            (i_sys_rst),
    .i_tx_active          (i_tx_active),
    .i_sync_detected      (i_sync_detected),
    .i_packet_end         (i_packet_end),
    .i_addr_reject        (i_addr_reject),
    .i_rx_overflow_enter  (i_rx_overflow_enter),
    .i_tx_underflow_enter (i_tx_underflow_enter),
    .o_sync_found         (sync_found)
  );

  // ==========================================================================
  // crc result flag
  logic crc_ok;
  logic crc_set;
  logic crc_clear;

  // a failed check also clears, so the bit always describes the latest packet
  assign crc_set   = i_crc_done & i_crc_match;
  assign crc_clear = i_crc_done | i_rx_start;

  // a matching result in the cycle of a receiver restart wins over the clear
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      crc_ok <= radio_status_pkg::RST_FLAG;
    end else if (crc_set) begin
      crc_ok <= 1'b1;
    end else if (crc_clear) begin
      crc_ok <= 1'b0;
    end
  end

  // ==========================================================================
  // sampled status values
  logic [15:0] wake_timer;
  logic [7:0]  synth_cal;
  logic [6:0]  tx_count;
  logic        tx_underrun;
  logic [6:0]  rx_count;
  logic        rx_overrun;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wake_timer <= radio_status_pkg::RST_TIMER;
    end else begin
      wake_timer <= i_wake_timer;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      synth_cal <= radio_status_pkg::RST_BYTE;
    end else begin
      synth_cal <= i_synth_cal;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tx_count    <= radio_status_pkg::RST_OSC_CAL;
      tx_underrun <= radio_status_pkg::RST_FLAG;
    end else begin
      tx_count    <= i_tx_byte_count;
      tx_underrun <= i_tx_queue_underrun;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_count    <= radio_status_pkg::RST_OSC_CAL;
      rx_overrun  <= radio_status_pkg::RST_FLAG;
    end else begin
      rx_count    <= i_rx_byte_count;
      rx_overrun  <= i_rx_queue_overrun;
    end
  end

  // ==========================================================================
  // oscillator calibration results
  logic [6:0] osc_cal_a;
  logic [6:0] osc_cal_b;

  // held between runs; a run that never finishes leaves the old pair intact
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      osc_cal_a <= radio_status_pkg::RST_OSC_CAL;
      osc_cal_b <= radio_status_pkg::RST_OSC_CAL;
    end else if (i_osc_cal_done) begin
      osc_cal_a <= i_osc_cal_a;
      osc_cal_b <= i_osc_cal_b;
    end
  end

  // ==========================================================================
  // packet status byte
  logic [7:0] packet_status;

  // pin bits carry the synchronised pin levels as they arrive; a host polling for lock
  // through them may see glitches
  always_comb begin
    packet_status                                     = radio_status_pkg::RST_BYTE;
    packet_status[radio_status_pkg::POS_CRC_OK]        = crc_ok;
    packet_status[radio_status_pkg::POS_CARRIER_SENSE] = carrier_sense_s;
    packet_status[radio_status_pkg::POS_PREAMBLE_MET]  = preamble_met_s;
    packet_status[radio_status_pkg::POS_CHANNEL_CLEAR] = channel_clear_s;
    packet_status[radio_status_pkg::POS_SYNC_FOUND]    = sync_found;
    packet_status[radio_status_pkg::POS_PIN2]          = pin2_s;
    packet_status[radio_status_pkg::POS_PIN0]          = pin0_s;
  end

  // ==========================================================================
  // read multiplexer
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = radio_status_pkg::RST_BYTE;
    case (i_rd_addr)
      radio_status_pkg::OFS_WAKE_TIMER_HIGH: begin
        next_rd_data = wake_timer[15:8];
      end
      radio_status_pkg::OFS_WAKE_TIMER_LOW: begin
        next_rd_data = wake_timer[7:0];
      end
      radio_status_pkg::OFS_PACKET_STATUS: begin
        next_rd_data = packet_status;
      end
      radio_status_pkg::OFS_SYNTH_CAL: begin
        next_rd_data = synth_cal;
      end
      radio_status_pkg::OFS_TX_FILL_LEVEL: begin
        next_rd_data = {tx_underrun, tx_count};
      end
      radio_status_pkg::OFS_RX_FILL_LEVEL: begin
        next_rd_data = {rx_overrun, rx_count};
      end
      radio_status_pkg::OFS_OSC_CAL_A: begin
        next_rd_data = {1'b0, osc_cal_a};
      end
      radio_status_pkg::OFS_OSC_CAL_B: begin
        next_rd_data = {1'b0, osc_cal_b};
      end
      default: begin
        next_rd_data = radio_status_pkg::RST_BYTE;
      end
    endcase
    if (!is_mapped(i_rd_addr)) begin
      next_rd_data = radio_status_pkg::RST_BYTE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_valid <= radio_status_pkg::RST_FLAG;
    end else begin
      o_rd_valid <= i_rd_en;
    end
  end

  // read data holds between reads so a late pick-up by the host still works
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= radio_status_pkg::RST_BYTE;
    end else if (i_rd_en) begin
      o_rd_data <= next_rd_data;
    end
  end

  // ==========================================================================
  // write path: everything here is read only, writes to a mapped offset only raise a notice
  logic       wr_hit;
  logic [7:0] wr_data_unused;

  assign wr_hit         = i_wr_en & is_mapped(i_wr_addr);
  assign wr_data_unused = i_wr_data;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_wr_ignored <= radio_status_pkg::RST_FLAG;
    end else begin
      o_wr_ignored <= wr_hit;
    end
  end

  // ==========================================================================
  // flag copies for the rest of the chip
  // one cycle behind the status byte; a poll and a copy may differ for a cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_crc_ok <= radio_status_pkg::RST_FLAG;
    end else begin
      o_crc_ok <= crc_ok;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_sync_found <= radio_status_pkg::RST_FLAG;
    end else begin
      o_sync_found <= sync_found;
    end
  end

endmodule

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  input  wire logic       i_wr_ignored,
  output logic            o_rd_en,
  output logic [5:0]      o_rd_addr,
  output logic            o_wr_en,
  output logic [5:0]      o_wr_addr,
  output logic [7:0]      o_wr_data
);
  // ==========================================================================
  // bus cycles; lock is never judged from a pin bit
  initial begin
    {o_rd_en, o_wr_en} = 2'h0;
    {o_rd_addr, o_wr_addr, o_wr_data} = 20'h0_0000;
  end
  // released lines show the inverse so a stale offset cannot pass
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1 o_rd_en = 1'b1;
    o_rd_addr = a;
    @(posedge i_sys_clk);
    #1 o_rd_en = 1'b0;
    o_rd_addr = ~a;
    d = i_rd_valid ? i_rd_data : 8'hxx;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v, output logic ign);
    @(posedge i_sys_clk);
    #1 o_wr_en = 1'b1;
    o_wr_addr = a;
    o_wr_data = v;
    @(posedge i_sys_clk);
    #1 o_wr_en = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~v;
    ign = i_wr_ignored;
  endtask
endmodule

// ---- tb/radio_status_sva.sv ----
`timescale 1ns/1ps
module radio_status_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_rd_en,
  input wire logic [5:0]  i_rd_addr,
  input wire logic        i_wr_en,
  input wire logic [5:0]  i_wr_addr,
  input wire logic [15:0] i_wake_timer,
  input wire logic        i_crc_done,
  input wire logic        i_crc_match,
  input wire logic        i_rx_start,
  input wire logic        i_sync_detected,
  input wire logic        i_addr_reject,
  input wire logic        i_rx_overflow_enter,
  input wire logic        i_tx_underflow_enter,
  input wire logic        i_tx_active,
  input wire logic [6:0]  i_tx_byte_count,
  input wire logic        i_tx_queue_underrun,
  input wire logic [6:0]  i_rx_byte_count,
  input wire logic        i_rx_queue_overrun,
  input wire logic [7:0]  o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic        o_wr_ignored,
  input wire logic        o_crc_ok,
  input wire logic        o_sync_found
);
  // ==========================================================================
  // helpers
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic [7:0] wt_hi = i_wake_timer[15:8];
  wire logic [7:0] tx_b  = {i_tx_queue_underrun, i_tx_byte_count};
  wire logic [7:0] rx_b  = {i_rx_queue_overrun, i_rx_byte_count};
  wire logic       wr_hit = i_wr_en && (i_wr_addr >= 6'h36) && (i_wr_addr <= 6'h3d);
  wire logic       rx_clr = !i_tx_active && (i_addr_reject || i_rx_overflow_enter);
  // skip reads right after reset: the value registers were still cleared
  sequence rd_at(logic [5:0] a);
    !$past(i_sys_rst) && i_rd_en && i_rd_addr == a;
  endsequence
  // ==========================================================================
  // assertions
  AST_RD_VALID: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  AST_TIMER_HI: assert property (rd_at(6'h36) |=> o_rd_data == $past(wt_hi, 2))
    else $error("timer upper byte wrong");
  AST_TX_FILL: assert property (rd_at(6'h3a) |=> o_rd_data == $past(tx_b, 2))
    else $error("tx fill wrong");
  AST_RX_FILL: assert property (rd_at(6'h3b) |=> o_rd_data == $past(rx_b, 2))
    else $error("rx fill wrong");
  AST_WR_HIT: assert property (wr_hit |=> o_wr_ignored)
    else $error("write not flagged");
  AST_CRC_SET: assert property (i_crc_done && i_crc_match |-> ##2 o_crc_ok)
    else $error("crc flag not set");
  AST_CRC_CLR: assert property (i_rx_start && !i_crc_done |-> ##2 !o_crc_ok)
    else $error("crc flag not cleared");
  AST_SYNC_SET: assert property (i_sync_detected |-> ##2 o_sync_found)
    else $error("sync flag not set");
  AST_SYNC_RX: assert property (rx_clr && !i_sync_detected |-> ##2 !o_sync_found)
    else $error("sync flag not cleared in receive");
  AST_SYNC_TX: assert property (i_tx_active && i_tx_underflow_enter && !i_sync_detected
    |-> ##2 !o_sync_found)
    else $error("sync flag not cleared in transmit");
endmodule
bind radio_status_register_bank radio_status_sva chk_u (.*);

// ---- tb/radio_status_register_bank_tb.sv ----
`timescale 1ns/1ps
module radio_status_register_bank_tb;
  localparam logic [8:0] CRC_OK = 9'h180, CRC_BAD = 9'h100, RXS = 9'h040, SYN = 9'h020;
  localparam logic [8:0] PEND = 9'h010, REJ = 9'h008, OVF = 9'h004, UNF = 9'h002;
  localparam logic [8:0] OSC = 9'h001;
  logic        i_sys_clk, i_sys_rst, i_rd_en, i_wr_en, i_tx_active;
  logic [5:0]  i_rd_addr, i_wr_addr;
  logic [7:0]  i_wr_data, i_synth_cal, o_rd_data;
  logic [15:0] i_wake_timer;
  logic        i_crc_done, i_crc_match, i_rx_start, i_sync_detected, i_packet_end;
  logic        i_addr_reject, i_rx_overflow_enter, i_tx_underflow_enter, i_osc_cal_done;
  logic        i_carrier_sense, i_preamble_quality_met, i_channel_clear;
  logic        i_general_out_pin_2, i_general_out_pin_0;
  logic [6:0]  i_tx_byte_count, i_rx_byte_count, i_osc_cal_a, i_osc_cal_b;
  logic        i_tx_queue_underrun, i_rx_queue_overrun;
  logic        o_rd_valid, o_wr_ignored, o_crc_ok, o_sync_found;
  logic [8:0]  evt;
  logic [4:0]  lv;
  int          n_fail, checks, cyc;
  assign {i_crc_done, i_crc_match, i_rx_start, i_sync_detected, i_packet_end, i_addr_reject,
          i_rx_overflow_enter, i_tx_underflow_enter, i_osc_cal_done} = evt;
  assign {i_carrier_sense, i_preamble_quality_met, i_channel_clear, i_general_out_pin_2,
          i_general_out_pin_0} = lv;
  radio_status_register_bank dut_u (.*);
  host_model host_u (
    .i_sys_clk    (i_sys_clk),
    .i_rd_data    (o_rd_data),
    .i_rd_valid   (o_rd_valid),
    .i_wr_ignored (o_wr_ignored),
    .o_rd_en      (i_rd_en),
    .o_rd_addr    (i_rd_addr),
    .o_wr_en      (i_wr_en),
    .o_wr_addr    (i_wr_addr),
    .o_wr_data    (i_wr_data)
  );
  // ==========================================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic tick();
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic ev(input logic [8:0] v);
    tick();
    evt = v;
    tick();
    evt = 9'h000;
  endtask
  // one event, then the status byte and both flag outputs must agree
  task automatic step(input logic [8:0] v, input logic tx, input logic [7:0] e);
    i_tx_active = tx;
    ev(v);
    rc(6'h38, e);
    chk({6'h00, o_crc_ok, o_sync_found}, {6'h00, e[7], e[3]});
  endtask
  // mid-run reset: both flags and the held calibration value A must come back cleared
  task automatic t_reset();
    ev(CRC_OK | SYN);
    i_sys_rst = 1'b1;
    repeat (2) tick();
    i_sys_rst = 1'b0;
    chk({4'h0, o_rd_valid, o_wr_ignored, o_crc_ok, o_sync_found}, 8'h00);
    rc(6'h3c, 8'h00);
    rc(6'h38, 8'h00);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_live();
    logic [4:0] p [3] = '{5'h15, 5'h0a, 5'h1f};
    foreach (p[k]) begin
      lv = p[k];
      repeat (3) tick();
      rc(6'h38, {1'b0, p[k][4:2], 1'b0, p[k][1], 1'b0, p[k][0]});
    end
    lv = 5'h00;
  endtask
  task automatic t_values();
    i_wake_timer = 16'ha55a;
    i_synth_cal = 8'h3c;
    {i_tx_queue_underrun, i_tx_byte_count} = 8'hc5;
    {i_rx_queue_overrun, i_rx_byte_count} = 8'h7f;
    {i_osc_cal_a, i_osc_cal_b} = {7'h7f, 7'h01};
    ev(OSC);
    {i_osc_cal_a, i_osc_cal_b} = {7'h00, 7'h55};
    rc(6'h36, 8'ha5);
    rc(6'h37, 8'h5a);
    rc(6'h39, 8'h3c);
    rc(6'h3a, 8'hc5);
    rc(6'h3b, 8'h7f);
    rc(6'h3c, 8'h7f);
    rc(6'h3d, 8'h01);
    rc(6'h3e, 8'h00);
    i_tx_queue_underrun = 1'b0;
    i_rx_queue_overrun = 1'b1;
    rc(6'h3a, 8'h45);
    rc(6'h3b, 8'hff);
  endtask
  task automatic t_writes();
    logic [5:0] a;
    logic       ign;
    for (a = 6'h35; a != 6'h3f; a++) begin
      host_u.wr(a, 8'hff, ign);
      chk({7'h00, ign}, {7'h00, (a >= 6'h36 && a <= 6'h3d)});
    end
    rc(6'h3a, 8'h45);
    rc(6'h3c, 8'h7f);
  endtask
  task automatic t_flags();
    step(CRC_OK, 1'b0, 8'h80);
    step(RXS, 1'b0, 8'h00);
    step(CRC_OK | RXS, 1'b0, 8'h80);
    step(CRC_BAD, 1'b0, 8'h00);
    step(SYN, 1'b0, 8'h08);
    step(REJ, 1'b0, 8'h00);
    step(SYN, 1'b0, 8'h08);
    step(OVF, 1'b0, 8'h00);
    step(SYN | UNF, 1'b0, 8'h08);
    step(PEND, 1'b0, 8'h00);
    step(SYN, 1'b1, 8'h08);
    step(SYN | PEND, 1'b1, 8'h08);
    step(REJ | OVF, 1'b1, 8'h08);
    step(UNF, 1'b1, 8'h00);
  endtask
  // ==========================================================================
  // clock, reset, run
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // a hang in any handshake ends the run well past the expected length
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    i_sys_rst = 1'b1;
    {evt, lv, i_tx_active, i_tx_queue_underrun, i_rx_queue_overrun} = 17'h0_0000;
    {i_wake_timer, i_synth_cal, i_tx_byte_count, i_rx_byte_count} = 38'h00_0000_0000;
    {i_osc_cal_a, i_osc_cal_b} = 14'h0000;
    repeat (6) @(posedge i_sys_clk);
    #1 i_sys_rst = 1'b0;
    t_live();
    t_values();
    t_writes();
    t_flags();
    t_reset();
    close_out();
  end
endmodule
